// *** inc/acc_pkg.sv ***
package acc_pkg;
   // Register addresses on the special function register bus
   localparam logic [7:0] ACC_ADDR_CONTROL = 8'hA1;
   localparam logic [7:0] ACC_ADDR_RESULT_HIGH = 8'hA2;
   localparam logic [7:0] ACC_ADDR_RESULT_LOW = 8'hA3;
   localparam logic [7:0] ACC_ADDR_STATIC = 8'hA4;
   localparam logic [7:0] ACC_ADDR_EXT_IRQ_FLAGS = 8'h91;

   // Reset values
   localparam logic [7:0] ACC_CONTROL_RST = 8'h80;
   localparam logic [7:0] ACC_STATIC_RST = 8'h0A;

   // adc_control fields
   localparam int ACC_CTL_REQUEST_BIT = 7;
   localparam int ACC_CTL_RUN_BIT = 6;
   localparam int ACC_CTL_POWER_BIT = 5;
   localparam int ACC_CTL_REF_BIT = 4;
   localparam int ACC_CTL_SEL_MSB = 3;
   localparam int ACC_CTL_SEL_LSB = 0;
   localparam logic [3:0] ACC_SEL_SUPPLY = 4'h8;

   // adc_static_config fields
   localparam int ACC_ST_DIFF_BIT = 7;
   localparam int ACC_ST_SLEEP_BIT = 6;
   localparam int ACC_ST_FAST_BIT = 5;
   localparam int ACC_ST_BIAS_MSB = 4;
   localparam int ACC_ST_BIAS_LSB = 2;
   localparam int ACC_ST_RES_MSB = 1;
   localparam int ACC_ST_RES_LSB = 0;

   // adc_result_low_status fields
   localparam int ACC_LOW_UNDER_BIT = 2;
   localparam int ACC_LOW_OVER_BIT = 1;
   localparam int ACC_LOW_RANGE_BIT = 0;

   // Bit of the converter interrupt flag in the extended flags register
   localparam int ACC_IRQ_FLAG_BIT = 4;

   // Converter clock division and conversion timing in converter cycles
   localparam int ACC_DIV_SLOW = 32;
   localparam int ACC_DIV_FAST = 8;
   localparam int ACC_MIN_BITS = 6;
   localparam int ACC_BITS_PER_CYCLE = 2;
   localparam int ACC_CONV_EXTRA = 3;
   localparam int ACC_CYCLE_EXTRA = 1;

   typedef enum logic {
      ACC_IDLE,
      ACC_CONV
   } acc_state_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } acc_sfr_req_t;

   typedef struct packed {
      logic power;
      logic sleep;
      logic start;
      logic ref_external;
      logic supply_monitor;
      logic differential;
      logic [3:0] input_sel;
      logic [2:0] bias;
      logic [1:0] resolution;
   } acc_core_ctrl_t;

   typedef struct packed {
      logic [11:0] data;
      logic underflow;
      logic overflow;
   } acc_core_result_t;
endpackage : acc_pkg

// *** logic/acc_clkdiv.sv ***
`timescale 1ns/10ps
module acc_clkdiv
   import acc_pkg::*;
#(
   parameter int SLOW_DIV = ACC_DIV_SLOW,
   parameter int FAST_DIV = ACC_DIV_FAST
) (
   input wire logic ref_clk_in,   // CPU clock
   input wire logic rstn_in,      // Synchronous reset, active low
   input wire logic run_in,       // Divider runs while powered
   input wire logic fast_in,      // Divide by FAST_DIV instead of SLOW_DIV
   output logic tick_out,         // One cycle at each converter rising edge
   output logic conv_clk_out      // Divided clock for the analog core
);
   localparam logic [5:0] SLOW_LAST = 6'(SLOW_DIV - 1);
   localparam logic [5:0] FAST_LAST = 6'(FAST_DIV - 1);

   logic [5:0] cnt_reg;
   logic [5:0] last;
   logic [5:0] cnt_next;

   // Terminal count follows the divide select
   assign last = fast_in ? FAST_LAST : SLOW_LAST;
   assign cnt_next = (cnt_reg >= last) ? 6'h00 : cnt_reg + 6'h01;

   // Counter stops in power down so no edges reach the core
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in || !run_in) begin
         cnt_reg <= 6'h00;
         tick_out <= 1'b0;
         conv_clk_out <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         tick_out <= (cnt_next == 6'h00);
         conv_clk_out <= (cnt_next <= (last >> 1));
      end
   end
endmodule : acc_clkdiv

// *** logic/acc_top.sv ***
// Overview of operation
// - Start bit going high, low, high requests one conversion.
// - Start bit is resynchronised to converter clock before use.
// - Continuous-run bit converts back to back and ignores start bit.
// - Powered-on bit clear holds the whole converter powered down.
// - Reference select: internal when 0, external pin when 1, unless supply.
// - Input select 0-7 routes input n; 8 routes supply third, internal ref.
// - Differential mode: input zero inverting, selected input non-inverting.
// - Sleep bit puts the converter in reduced power mode.
// - Converter clock is CPU clock over 32, or over 8 when fast.
// - Three-bit bias trim is held and passed to the core.
// - Resolution field selects 6, 8, 10 or 12 bits and placement.
// - High result holds eight MSBs; top two zero at six bits.
// - Low result bits left-justified in bits 7-4; bit 3 unused.
// - Underflow sets low-register bit 2 and forces data to zeros.
// - Overflow sets low-register bit 1 and forces data to ones.
// - Low-register bit 0 reads underflow OR overflow.
// - Completed conversion sets the converter interrupt flag.
// - Single shot begins on third converter edge after start returns high.
// - Done pulse comes N/2+3 converter cycles after the start.
// - New start during a conversion aborts it and starts afresh.
// - Continuous conversions are spaced N/2+1 converter cycles apart.
// - The core resolves two result bits per converter cycle.
// - Interrupt flag stays set until cleared; software may also set it.
`timescale 1ns/10ps
module acc_top
   import acc_pkg::*;
#(
   parameter int SLOW_DIV = ACC_DIV_SLOW,
   parameter int FAST_DIV = ACC_DIV_FAST
) (
   input wire logic ref_clk_in,               // CPU clock, 25 MHz
   input wire logic rstn_in,                  // Synchronous reset, active low
   input wire acc_sfr_req_t sfr_req_in,       // SFR address, data, strobes
   input wire acc_core_result_t core_res_in,  // Analog core result
   output logic [7:0] sfr_rdata_out,          // Read data, one cycle later
   output acc_core_ctrl_t core_ctrl_out,      // Controls to the analog core
   output logic converter_clock_out,          // Divided clock to the core
   output logic done_pulse_out,               // Result valid pulse
   output logic irq_flag_out                  // Converter interrupt flag
);
   logic [7:0] control_reg;
   logic [7:0] static_reg;
   logic [7:0] high_reg;
   logic [7:0] low_reg;
   logic flag_reg;
   logic req_sync1_reg;
   logic req_sync2_reg;
   logic req_prev_reg;
   acc_state_t state_reg;
   logic [3:0] cnt_reg;
   logic core_start_reg;
   logic done_reg;
   logic tick;
   logic conv_clk;

   logic powered;
   logic run_mode;
   logic [1:0] res;
   logic [3:0] conv_len;
   logic [3:0] cycle_len;
   logic start_ev;
   logic finish;
   logic wr_control;
   logic wr_static;
   logic wr_flags;

   // Field decode
   assign powered = control_reg[ACC_CTL_POWER_BIT];
   assign run_mode = control_reg[ACC_CTL_RUN_BIT];
   assign res = static_reg[ACC_ST_RES_MSB:ACC_ST_RES_LSB];

   // Write strobes for the writable registers
   assign wr_control = sfr_req_in.wr && (sfr_req_in.addr == ACC_ADDR_CONTROL);
   assign wr_static = sfr_req_in.wr && (sfr_req_in.addr == ACC_ADDR_STATIC);
   assign wr_flags = sfr_req_in.wr &&
                     (sfr_req_in.addr == ACC_ADDR_EXT_IRQ_FLAGS);

   // Lengths in converter cycles; N/2 core cycles at two bits each
   assign conv_len = 4'((ACC_MIN_BITS / ACC_BITS_PER_CYCLE) + ACC_CONV_EXTRA)
                     + {2'b00, res};
   assign cycle_len = 4'((ACC_MIN_BITS / ACC_BITS_PER_CYCLE) + ACC_CYCLE_EXTRA)
                      + {2'b00, res};

   // Converter clock divider, halted in power down
   acc_clkdiv #(
      .SLOW_DIV(SLOW_DIV),
      .FAST_DIV(FAST_DIV)
   ) u_clkdiv (
      .ref_clk_in(ref_clk_in),
      .rstn_in(rstn_in),
      .run_in(powered),
      .fast_in(static_reg[ACC_ST_FAST_BIT]),
      .tick_out(tick),
      .conv_clk_out(conv_clk)
   );

   // Control register; start bit is plain storage here
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         control_reg <= ACC_CONTROL_RST;
      end else if (wr_control) begin
         control_reg <= sfr_req_in.wdata;
      end
   end

   // Static configuration register
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         static_reg <= ACC_STATIC_RST;
      end else if (wr_static) begin
         static_reg <= sfr_req_in.wdata;
      end
   end

   // Start bit into converter timing, sampled on converter edges only
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in || !powered) begin
         req_sync1_reg <= 1'b1;
         req_sync2_reg <= 1'b1;
         req_prev_reg <= 1'b1;
      end else if (tick) begin
         req_sync1_reg <= control_reg[ACC_CTL_REQUEST_BIT];
         req_sync2_reg <= req_sync1_reg;
         req_prev_reg <= req_sync2_reg;
      end
   end

   // Rising edge of the synchronised bit proves a low phase was seen
   assign start_ev = tick && req_sync2_reg && !req_prev_reg
                     && !run_mode;
   assign finish = tick && (state_reg == ACC_CONV) && (cnt_reg == 4'h1)
                   && !start_ev;

   // Conversion sequencer
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in || !powered) begin
         state_reg <= ACC_IDLE;
         cnt_reg <= 4'h0;
         core_start_reg <= 1'b0;
      end else begin
         core_start_reg <= 1'b0;
         unique case (state_reg)
            ACC_IDLE: begin
               if (start_ev || (tick && run_mode)) begin
                  state_reg <= ACC_CONV;
                  cnt_reg <= conv_len;
                  core_start_reg <= 1'b1;
               end
            end
            ACC_CONV: begin
               if (start_ev) begin
                  cnt_reg <= conv_len;
                  core_start_reg <= 1'b1;
               end else if (finish) begin
                  if (run_mode) begin
                     cnt_reg <= cycle_len;
                     core_start_reg <= 1'b1;
                  end else begin
                     state_reg <= ACC_IDLE;
                     cnt_reg <= 4'h0;
                  end
               end else if (tick) begin
                  cnt_reg <= cnt_reg - 4'h1;
               end
            end
         endcase
      end
   end

   // Result placement; unfilled bits stay zero
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         high_reg <= 8'h00;
         low_reg <= 8'h00;
      end else if (finish) begin
         logic [11:0] d;
         d = core_res_in.data;
         if (core_res_in.underflow) begin
            d = 12'h000;
         end else if (core_res_in.overflow) begin
            d = 12'hFFF;
         end
         unique case (res)
            2'b00: begin
               high_reg <= {2'b00, d[11:6]};
               low_reg[7:4] <= 4'h0;
            end
            2'b01: begin
               high_reg <= d[11:4];
               low_reg[7:4] <= 4'h0;
            end
            2'b10: begin
               high_reg <= d[11:4];
               low_reg[7:4] <= {d[3:2], 2'b00};
            end
            2'b11: begin
               high_reg <= d[11:4];
               low_reg[7:4] <= d[3:0];
            end
         endcase
         low_reg[3] <= 1'b0;
         low_reg[ACC_LOW_UNDER_BIT] <= core_res_in.underflow;
         low_reg[ACC_LOW_OVER_BIT] <= core_res_in.overflow;
         low_reg[ACC_LOW_RANGE_BIT] <= core_res_in.underflow
                                     | core_res_in.overflow;
      end
   end

   // Done pulse, one CPU cycle wide, as results land
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         done_reg <= 1'b0;
      end else begin
         done_reg <= finish;
      end
   end

   // Interrupt flag; a completion in the clearing cycle still sets it
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         flag_reg <= 1'b0;
      end else if (done_reg) begin
         flag_reg <= 1'b1;
      end else if (wr_flags) begin
         flag_reg <= sfr_req_in.wdata[ACC_IRQ_FLAG_BIT];
      end
   end

   // Read data, registered so the bus sees a flop
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         sfr_rdata_out <= 8'h00;
      end else if (sfr_req_in.rd) begin
         unique case (sfr_req_in.addr)
            ACC_ADDR_CONTROL: sfr_rdata_out <= control_reg;
            ACC_ADDR_RESULT_HIGH: sfr_rdata_out <= high_reg;
            ACC_ADDR_RESULT_LOW: sfr_rdata_out <= low_reg;
            ACC_ADDR_STATIC: sfr_rdata_out <= static_reg;
            ACC_ADDR_EXT_IRQ_FLAGS: begin
               sfr_rdata_out <= 8'h00;
               sfr_rdata_out[ACC_IRQ_FLAG_BIT] <= flag_reg;
            end
            default: sfr_rdata_out <= 8'h00;
         endcase
      end
   end

   // Analog core controls, registered so outputs come from flops
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         core_ctrl_out <= '0;
      end else begin
         core_ctrl_out.power <= powered;
         core_ctrl_out.sleep <= static_reg[ACC_ST_SLEEP_BIT];
         core_ctrl_out.start <= core_start_reg;
         core_ctrl_out.input_sel <=
            control_reg[ACC_CTL_SEL_MSB:ACC_CTL_SEL_LSB];
         core_ctrl_out.supply_monitor <=
            (control_reg[ACC_CTL_SEL_MSB:ACC_CTL_SEL_LSB]
             == ACC_SEL_SUPPLY);
         // Supply measurement always uses the bandgap
         core_ctrl_out.ref_external <= control_reg[ACC_CTL_REF_BIT] &&
            (control_reg[ACC_CTL_SEL_MSB:ACC_CTL_SEL_LSB]
             != ACC_SEL_SUPPLY);
         core_ctrl_out.differential <= static_reg[ACC_ST_DIFF_BIT];
         core_ctrl_out.bias <=
            static_reg[ACC_ST_BIAS_MSB:ACC_ST_BIAS_LSB];
         core_ctrl_out.resolution <= res;
      end
   end

   // Remaining outputs
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         converter_clock_out <= 1'b0;
         done_pulse_out <= 1'b0;
         irq_flag_out <= 1'b0;
      end else begin
         converter_clock_out <= conv_clk;
         done_pulse_out <= done_reg;
         irq_flag_out <= flag_reg;
      end
   end
endmodule : acc_top

// *** tb/acc_core_model.sv ***
`timescale 1ns/10ps
module acc_core_model
   import acc_pkg::*;
(
   input wire logic ref_clk_in,         // CPU clock
   input wire acc_core_ctrl_t ctrl_in,  // Controls from the block
   input wire logic conv_clk_in,        // Converter clock
   input wire logic [1:0] mode_in,      // 0 normal, 1 under, 2 over
   input wire logic [11:0] level_in,    // Input level to convert
   output acc_core_result_t res_out     // Result toward the block
);
   logic [3:0] bits_reg;
   logic clk_d_reg;
   logic done;
   logic [11:0] mask;
   assign mask = 12'hFFF << (4'h6 - {1'b0, ctrl_in.resolution, 1'b0});
   assign done = bits_reg >= 4'h6 + {1'b0, ctrl_in.resolution, 1'b0};
   // Two bits settle per converter edge; until then the bus is junk
   always_ff @(posedge ref_clk_in) begin
      clk_d_reg <= conv_clk_in;
      if (ctrl_in.start)
         bits_reg <= 4'h0;
      else if (conv_clk_in && !clk_d_reg && !done)
         bits_reg <= bits_reg + 4'h2;
   end
   // Unfilled low bits driven high so the block must drop them
   assign res_out.data = done ? ((level_in & mask) | ~mask) : ~level_in;
   assign res_out.underflow = done ? mode_in == 2'h1 : 1'b1;
   assign res_out.overflow = done ? mode_in == 2'h2 : 1'b1;
endmodule : acc_core_model

// *** tb/acc_top_checker.sv ***
`timescale 1ns/10ps
module acc_top_checker
   import acc_pkg::*;
#(
   parameter int SLOW_DIV = ACC_DIV_SLOW,
   parameter int FAST_DIV = ACC_DIV_FAST
) (
   input wire logic ref_clk_in,            // CPU clock
   input wire logic rstn_in,               // Reset, active low
   input wire acc_sfr_req_t sfr_req_in,    // Register bus request
   input wire logic [7:0] sfr_rdata_out,   // Read data
   input wire acc_core_ctrl_t core_ctrl_out, // Core controls
   input wire logic converter_clock_out,   // Converter clock
   input wire logic done_pulse_out,        // Result valid pulse
   input wire logic irq_flag_out           // Interrupt flag
);
   logic fast_reg;
   logic cont_reg;
   logic seen_reg;
   logic [7:0] since_reg;
   logic [7:0] gap_reg;
   logic wflag;
   int per;
   assign wflag = sfr_req_in.wr && sfr_req_in.addr == ACC_ADDR_EXT_IRQ_FLAGS;
   assign per = fast_reg ? FAST_DIV : SLOW_DIV;
   // Mode bits shadowed from bus writes, the core does not show them
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         fast_reg <= 1'b0;
         cont_reg <= 1'b0;
      end else if (sfr_req_in.wr && sfr_req_in.addr == ACC_ADDR_STATIC) begin
         fast_reg <= sfr_req_in.wdata[ACC_ST_FAST_BIT];
      end else if (sfr_req_in.wr && sfr_req_in.addr == ACC_ADDR_CONTROL) begin
         cont_reg <= sfr_req_in.wdata[ACC_CTL_RUN_BIT];
      end
   end
   // Saturating cycle counts since core start and since last done
   always_ff @(posedge ref_clk_in) begin
      since_reg <= core_ctrl_out.start ? 8'h00 :
         since_reg + {7'h00, since_reg != 8'hFF};
      gap_reg <= done_pulse_out ? 8'h00 :
         gap_reg + {7'h00, gap_reg != 8'hFF};
      seen_reg <= cont_reg && (seen_reg || done_pulse_out);
   end
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rstn_in);
   a_conv_time: assert property (done_pulse_out && !cont_reg && !$past(cont_reg, 3)
      |-> since_reg == (int'(core_ctrl_out.resolution) + 6) * per - 1)
      else $error("done pulse late or early after start");
   a_cont_gap: assert property (done_pulse_out && cont_reg && seen_reg
      |-> gap_reg == (int'(core_ctrl_out.resolution) + 4) * per - 1)
      else $error("continuous done spacing wrong");
   a_done_single: assert property (done_pulse_out |=> !done_pulse_out)
      else $error("done pulse wider than one cycle");
   a_irq_on_done: assert property (done_pulse_out |-> ##[1:3] irq_flag_out)
      else $error("flag not set by completion");
   a_irq_holds: assert property (irq_flag_out && !wflag && !$past(wflag)
      |=> irq_flag_out)
      else $error("flag dropped without a write");
   a_power_off: assert property (!core_ctrl_out.power [*3]
      |-> !converter_clock_out && !done_pulse_out)
      else $error("converter active while powered down");
   a_supply_ref: assert property (core_ctrl_out.supply_monitor |->
      !core_ctrl_out.ref_external && core_ctrl_out.input_sel == ACC_SEL_SUPPLY)
      else $error("supply input without internal reference");
   a_range_bit: assert property ($past(sfr_req_in.rd) &&
      $past(sfr_req_in.addr) == ACC_ADDR_RESULT_LOW |->
      sfr_rdata_out[0] == (sfr_rdata_out[2] | sfr_rdata_out[1]) &&
      !sfr_rdata_out[3])
      else $error("range bit or unused bit wrong");
endmodule : acc_top_checker
bind acc_top acc_top_checker #(.SLOW_DIV(SLOW_DIV), .FAST_DIV(FAST_DIV))
   acc_top_checker_inst (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
   .sfr_req_in(sfr_req_in), .sfr_rdata_out(sfr_rdata_out),
   .core_ctrl_out(core_ctrl_out), .converter_clock_out(converter_clock_out),
   .done_pulse_out(done_pulse_out), .irq_flag_out(irq_flag_out));

// *** tb/acc_top_tb_top.sv ***
`timescale 1ns/10ps
module acc_top_tb_top;
   import acc_pkg::*;
   localparam int FAST = 2;
   localparam logic [11:0] LEVEL = 12'hA5C;
   logic clk, rstn, cclk, done, irq;
   acc_sfr_req_t req;
   acc_core_result_t res;
   acc_core_ctrl_t ctrl;
   logic [7:0] rdata;
   logic [1:0] mode;
   int n_mismatch, tests_run, cyc, n, k;
   acc_top #(.SLOW_DIV(4), .FAST_DIV(FAST)) acc_top_inst (.ref_clk_in(clk),
      .rstn_in(rstn), .sfr_req_in(req), .core_res_in(res),
      .sfr_rdata_out(rdata), .core_ctrl_out(ctrl),
      .converter_clock_out(cclk), .done_pulse_out(done), .irq_flag_out(irq));
   acc_core_model acc_core_model_inst (.ref_clk_in(clk), .ctrl_in(ctrl),
      .conv_clk_in(cclk), .mode_in(mode), .level_in(LEVEL), .res_out(res));
   task automatic check(input string what, input logic [11:0] seen,
         input logic [11:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : tally_and_finish
   // Bus cycles: one strobe cycle, then an idle edge so strobes never merge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      req = '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      #1 req = '0;
      @(posedge clk);
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string w);
      req = '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk);
      #1 req = '0;
      check(w, rdata, exp);
      @(posedge clk);
      #1;
   endtask : rd
   task automatic step(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask : step
   // High, low held past two slow converter periods, high again
   task automatic kick(input logic [7:0] c);
      wr(ACC_ADDR_CONTROL, c | 8'h80);
      wr(ACC_ADDR_CONTROL, c);
      step(12);
      wr(ACC_ADDR_CONTROL, c | 8'h80);
   endtask : kick
   task automatic wait_done();
      k = 0;
      while (done !== 1'b1 && k < 400) begin
         step(1);
         k++;
      end
      check("done seen", k < 400, 12'h1);
   endtask : wait_done
   task automatic t_regs();
      check("power at reset", ctrl.power, 12'h0);
      rd(ACC_ADDR_CONTROL, 8'h80, "control reset");
      rd(ACC_ADDR_STATIC, 8'h0A, "static reset");
      wr(ACC_ADDR_RESULT_HIGH, 8'hFF);
      rd(ACC_ADDR_RESULT_HIGH, 8'h00, "result high read only");
      rd(8'hB0, 8'h00, "unmapped read");
      wr(ACC_ADDR_EXT_IRQ_FLAGS, 8'h10);
      step(1);
      check("software flag set", irq, 12'h1);
      rd(ACC_ADDR_EXT_IRQ_FLAGS, 8'h10, "flag readback");
      wr(ACC_ADDR_EXT_IRQ_FLAGS, 8'h00);
   endtask : t_regs
   task automatic t_fields();
      wr(ACC_ADDR_CONTROL, 8'h38);
      step(1);
      check("supply route", {ctrl.ref_external, ctrl.supply_monitor,
         ctrl.input_sel}, 12'h018);
      wr(ACC_ADDR_CONTROL, 8'h35);
      wr(ACC_ADDR_STATIC, 8'hDF);
      step(1);
      check("external ref route", {ctrl.ref_external, ctrl.supply_monitor,
         ctrl.input_sel}, 12'h025);
      check("static fields", {ctrl.differential, ctrl.sleep, ctrl.bias,
         ctrl.resolution}, 12'h07F);
      rd(ACC_ADDR_STATIC, 8'hDF, "static readback");
   endtask : t_fields
   task automatic t_single(input logic [1:0] r, input logic [1:0] m,
         input logic f);
      logic [11:0] d;
      d = (m == 2'h1) ? 12'h000 : (m == 2'h2) ? 12'hFFF : LEVEL;
      mode = m;
      wr(ACC_ADDR_STATIC, {2'b00, f, 3'b010, r});
      kick(8'h23);
      wait_done();
      rd(ACC_ADDR_RESULT_HIGH, (r == 2'h0) ? {2'b00, d[11:6]} : d[11:4],
         "result high");
      rd(ACC_ADDR_RESULT_LOW, {(r == 2'h3) ? d[3:0] : (r == 2'h2) ?
         {d[3:2], 2'b00} : 4'h0, 1'b0, m == 2'h1, m == 2'h2, m != 2'h0},
         "result low");
      check("flag after done", irq, 12'h1);
      wr(ACC_ADDR_EXT_IRQ_FLAGS, 8'h00);
      step(1);
      check("flag cleared", irq, 12'h0);
   endtask : t_single
   task automatic t_abort();
      mode = 2'h0;
      wr(ACC_ADDR_STATIC, 8'h0B);
      kick(8'h23);
      kick(8'h23);
      n = 0;
      repeat (150) begin
         step(1);
         if (done === 1'b1)
            n++;
      end
      check("one done after abort", n, 12'h1);
   endtask : t_abort
   task automatic t_cont();
      wr(ACC_ADDR_STATIC, 8'h29);
      wr(ACC_ADDR_CONTROL, 8'hE3);
      wr(ACC_ADDR_CONTROL, 8'h63);
      wr(ACC_ADDR_CONTROL, 8'hE3);
      wait_done();
      step(1);
      wait_done();
      check("run spacing", k + 1, (8 / 2 + 1) * FAST);
      wr(ACC_ADDR_CONTROL, 8'h00);
      n = 0;
      repeat (60) begin
         step(1);
         if (done === 1'b1 || cclk !== 1'b0)
            n++;
      end
      check("quiet when off", n, 12'h0);
   endtask : t_cont
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Cut a hang short well past the expected run length
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   initial begin
      rstn = 1'b0;
      req = '0;
      mode = 2'h0;
      n_mismatch = 0;
      tests_run = 0;
      cyc = 0;
      repeat (2) @(posedge clk);
      #1 rstn = 1'b1;
      t_regs();
      t_fields();
      for (int i = 0; i < 4; i++)
         t_single(i[1:0], 2'h0, i[0]);
      t_single(2'h3, 2'h1, 1'b1);
      t_single(2'h3, 2'h2, 1'b0);
      t_single(2'h0, 2'h2, 1'b0);
      t_abort();
      t_cont();
      tally_and_finish();
   end
endmodule : acc_top_tb_top
